// file: shared/tw_pkg.sv
package tw_pkg;
    localparam int TW_AW = 8;
    localparam int TW_DW = 32;
    localparam logic [7:0] TW_OFS_CTRL_A = 8'h24;
    localparam logic [7:0] TW_OFS_COMP = 8'h28;
    localparam logic [7:0] TW_OFS_CMP_A = 8'h2c;
    localparam logic [7:0] TW_OFS_CMP_B = 8'h30;
    localparam logic [7:0] TW_OFS_COUNT = 8'h34;
    localparam logic [7:0] TW_OFS_STATUS = 8'h38;
    localparam logic [7:0] TW_OFS_MASK = 8'h3c;
    localparam logic [7:0] TW_OFS_PIN_DIR = 8'h40;
    localparam logic [7:0] TW_REG_RESET = 8'h00;
    localparam logic [7:0] TW_CTRL_A_WMASK = 8'hf3;
    localparam logic [7:0] TW_COMP_WMASK = 8'h09;
    localparam logic [7:0] TW_IRQ_WMASK = 8'h07;
    localparam logic [7:0] TW_DIR_WMASK = 8'h03;
    localparam int TW_COM_A_LO = 6;
    localparam int TW_COM_B_LO = 4;
    localparam int TW_WGM_LO = 0;
    localparam int TW_COMP_RUN = 0;
    localparam int TW_COMP_WGM_HI = 3;
    localparam int TW_ST_OVF = 0;
    localparam int TW_ST_MATCH_A = 1;
    localparam int TW_DIR_A = 0;
    localparam int TW_DIR_B = 1;
    localparam logic [7:0] TW_MAX = 8'hff;
    localparam logic [7:0] TW_BOTTOM = 8'h00;
    localparam logic [1:0] TW_COM_OFF = 2'h0;
    localparam logic [1:0] TW_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TW_COM_CLEAR = 2'h2;
    localparam logic [1:0] TW_COM_SET = 2'h3;
    localparam logic [1:0] TW_RESP_OKAY = 2'h0;
    localparam logic [1:0] TW_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {TW_NORMAL, TW_CTC, TW_FAST, TW_PHASE, TW_RESV} tw_count_t;

    function automatic tw_count_t tw_mode_kind(input logic [2:0] mode);
        case (mode)
            3'h0: return TW_NORMAL;
            3'h2: return TW_CTC;
            3'h3, 3'h7: return TW_FAST;
            3'h1, 3'h5: return TW_PHASE;
            default: return TW_RESV;
        endcase
    endfunction
endpackage

// file: hw/tw_waveform_ctrl.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tw_waveform_ctrl (
    // clock and reset
    input logic clk,
    input logic rst,
    // axi4-lite write
    input logic [tw_pkg::TW_AW-1:0] awaddr,
    input logic awvalid,
    output logic awready,
    input logic [tw_pkg::TW_DW-1:0] wdata,
    input logic [3:0] wstrb,
    input logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input logic bready,
    // axi4-lite read
    input logic [tw_pkg::TW_AW-1:0] araddr,
    input logic arvalid,
    output logic arready,
    output logic [tw_pkg::TW_DW-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input logic rready,
    // compare pins
    input logic port_out_a,
    input logic port_out_b,
    output logic pin_a_out,
    output logic pin_a_oe,
    output logic pin_b_out,
    output logic pin_b_oe,
    // interrupt
    output logic irq
);
    import tw_pkg::*;

    localparam int TW_WR_LAT_MIN = 1;
    localparam int TW_WR_LAT_MAX = 3;

    logic [7:0] ctrl_q, comp_q, mask_q, dir_q, st_q, count_q, top, rd_val, st_evt, st_clr;
    logic [7:0] cmp_buf_q [2];
    logic [7:0] cmp_act_q [2];
    logic [1:0] oc_q, hit, conn;
    logic [7:0] waddr_q, wdata_q;
    logic aw_held_q, w_held_q, wstrb_q, bvalid_q, rvalid_q, rd_ctrl_q, up_q;
    logic [1:0] bresp_q, rresp_q;
    logic [7:0] rdata_q;
    logic wr_fire, rd_fire, hb, run, at_top, ovf_evt, load, pwm;
    tw_count_t kind;

    function automatic logic addr_known(input logic [7:0] a);
        case (a)
            TW_OFS_CTRL_A, TW_OFS_COMP, TW_OFS_CMP_A, TW_OFS_CMP_B,
            TW_OFS_COUNT, TW_OFS_STATUS, TW_OFS_MASK, TW_OFS_PIN_DIR: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic oc_next(input tw_count_t k, input logic [1:0] com,
        input logic tog_ok, input logic oc, input logic hit_i, input logic up,
        input logic top_evt, input logic cmp_top);
        logic r;
        r = oc;
        case (k)
            TW_NORMAL, TW_CTC: begin
                if (hit_i) begin
                    case (com)
                        TW_COM_TOGGLE: r = ~oc;
                        TW_COM_CLEAR: r = 1'b0;
                        TW_COM_SET: r = 1'b1;
                        default: r = oc;
                    endcase
                end
            end
            TW_FAST: begin
                if (com == TW_COM_TOGGLE) begin
                    if (hit_i && tog_ok) r = ~oc;
                end else if (com[1]) begin
                    // wrap wins over a match at TOP
                    if (top_evt) r = ~com[0];
                    else if (hit_i) r = com[0];
                end
            end
            TW_PHASE: begin
                if (com == TW_COM_TOGGLE) begin
                    if (hit_i && tog_ok) r = ~oc;
                end else if (com[1]) begin
                    if (top_evt && cmp_top) r = ~com[0];
                    else if (hit_i && !cmp_top) r = up ? com[0] : ~com[0];
                end
            end
            default: r = oc;
        endcase
        return r;
    endfunction

    // mode decode
    assign hb = comp_q[TW_COMP_WGM_HI];
    assign run = comp_q[TW_COMP_RUN];
    assign kind = tw_mode_kind({hb, ctrl_q[TW_WGM_LO +: 2]});
    assign pwm = (kind == TW_FAST) || (kind == TW_PHASE);
    assign top = ((kind == TW_CTC) || hb) ? cmp_act_q[0] : TW_MAX;
    assign at_top = (count_q == top);
    assign load = !pwm || (run && at_top);

    // axi handshakes
    assign awready = !aw_held_q;
    assign wready = !w_held_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = !rvalid_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = {24'h000000, rdata_q};
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign rd_fire = arvalid && !rvalid_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 8'h00;
            wstrb_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= TW_RESP_OKAY;
        end else begin
            if (awvalid && !aw_held_q) begin
                aw_held_q <= 1'b1;
                waddr_q <= awaddr;
            end
            if (wvalid && !w_held_q) begin
                w_held_q <= 1'b1;
                wdata_q <= wdata[7:0];
                wstrb_q <= wstrb[0];
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= addr_known(waddr_q) ? TW_RESP_OKAY : TW_RESP_SLVERR;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // register file
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= TW_REG_RESET;
            comp_q <= TW_REG_RESET;
            cmp_buf_q[0] <= TW_REG_RESET;
            cmp_buf_q[1] <= TW_REG_RESET;
            mask_q <= TW_REG_RESET;
            dir_q <= TW_REG_RESET;
        end else if (wr_fire && wstrb_q) begin
            case (waddr_q)
                TW_OFS_CTRL_A: ctrl_q <= wdata_q & TW_CTRL_A_WMASK;
                TW_OFS_COMP: comp_q <= wdata_q & TW_COMP_WMASK;
                TW_OFS_CMP_A: cmp_buf_q[0] <= wdata_q;
                TW_OFS_CMP_B: cmp_buf_q[1] <= wdata_q;
                TW_OFS_MASK: mask_q <= wdata_q & TW_IRQ_WMASK;
                TW_OFS_PIN_DIR: dir_q <= wdata_q & TW_DIR_WMASK;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (araddr)
            TW_OFS_CTRL_A: rd_val = ctrl_q;
            TW_OFS_COMP: rd_val = comp_q;
            TW_OFS_CMP_A: rd_val = cmp_buf_q[0];
            TW_OFS_CMP_B: rd_val = cmp_buf_q[1];
            TW_OFS_COUNT: rd_val = count_q;
            TW_OFS_STATUS: rd_val = st_q;
            TW_OFS_MASK: rd_val = mask_q;
            TW_OFS_PIN_DIR: rd_val = dir_q;
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 8'h00;
            rresp_q <= TW_RESP_OKAY;
            rd_ctrl_q <= 1'b0;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= addr_known(araddr) ? TW_RESP_OKAY : TW_RESP_SLVERR;
            rd_ctrl_q <= (araddr == TW_OFS_CTRL_A);
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // sticky status, read clears, set wins
    assign st_clr = (rd_fire && araddr == TW_OFS_STATUS) ? 8'hff : 8'h00;
    assign st_evt = {5'h00, hit, ovf_evt};
    assign irq = |(st_q & mask_q);

    always_ff @(posedge clk) begin
        if (rst) st_q <= TW_REG_RESET;
        else st_q <= (st_q & ~st_clr) | st_evt;
    end

    always_comb begin
        case (kind)
            TW_NORMAL, TW_CTC: ovf_evt = run && (count_q == TW_MAX);
            TW_FAST: ovf_evt = run && at_top;
            TW_PHASE: ovf_evt = run && (count_q == TW_BOTTOM);
            default: ovf_evt = 1'b0;
        endcase
    end

    // counter
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= TW_BOTTOM;
            up_q <= 1'b1;
        end else if (run) begin
            case (kind)
                TW_NORMAL: count_q <= count_q + 8'h01;
                TW_CTC, TW_FAST: count_q <= at_top ? TW_BOTTOM : count_q + 8'h01;
                TW_PHASE: begin
                    if (up_q) begin
                        if (count_q >= top) begin
                            up_q <= 1'b0;
                            count_q <= (count_q == TW_BOTTOM) ? count_q : count_q - 8'h01;
                        end else begin
                            count_q <= count_q + 8'h01;
                        end
                    end else if (count_q == TW_BOTTOM) begin
                        up_q <= 1'b1;
                        count_q <= (top == TW_BOTTOM) ? count_q : count_q + 8'h01;
                    end else begin
                        count_q <= count_q - 8'h01;
                    end
                end
                default: count_q <= count_q;
            endcase
            if (!pwm) up_q <= 1'b1;
        end
    end

    // compare channels
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        localparam int LO = (ch == 0) ? TW_COM_A_LO : TW_COM_B_LO;
        logic [1:0] com;
        logic tog_ok;
        assign com = ctrl_q[LO +: 2];
        assign tog_ok = (ch == 0) && hb;
        assign hit[ch] = run && (count_q == cmp_act_q[ch]);
        assign conn[ch] = (com != TW_COM_OFF) && !(pwm && com == TW_COM_TOGGLE && !tog_ok && ch == 0);

        always_ff @(posedge clk) begin
            if (rst) cmp_act_q[ch] <= TW_REG_RESET;
            else if (load) cmp_act_q[ch] <= cmp_buf_q[ch];
        end

        always_ff @(posedge clk) begin
            if (rst) oc_q[ch] <= 1'b0;
            else if (run) oc_q[ch] <= oc_next(kind, com, tog_ok, oc_q[ch], hit[ch], up_q,
                at_top, cmp_act_q[ch] == top);
        end
    end

    // pin routing
    assign pin_a_out = conn[0] ? oc_q[0] : port_out_a;
    assign pin_b_out = conn[1] ? oc_q[1] : port_out_b;
    assign pin_a_oe = dir_q[TW_DIR_A];
    assign pin_b_oe = dir_q[TW_DIR_B];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_fast_wrap;
        run && kind == TW_FAST && at_top;
    endsequence
    sequence s_both_taken;
        awvalid && awready && wvalid && wready;
    endsequence

    chk_route_pin_a: assert property (
        conn[0] && dir_q[TW_DIR_A] |-> pin_a_oe && pin_a_out == oc_q[0])
        else $error("compare a not on pin");
    chk_drive_dir_b: assert property (!dir_q[TW_DIR_B] |-> !pin_b_oe)
        else $error("pin b driven while input");
    chk_toggle_normal: assert property (
        kind == TW_NORMAL && ctrl_q[TW_COM_A_LO +: 2] == TW_COM_TOGGLE && hit[0]
        |=> $changed(oc_q[0])) else $error("no toggle on match");
    chk_clear_ctc: assert property (
        kind == TW_CTC && ctrl_q[TW_COM_B_LO +: 2] == TW_COM_CLEAR && hit[1] |=> !oc_q[1])
        else $error("no clear on match");
    chk_fast_set_bottom: assert property (
        s_fast_wrap and ctrl_q[TW_COM_A_LO +: 2] == TW_COM_CLEAR |=> oc_q[0])
        else $error("no set at bottom");
    chk_fast_b_resv: assert property (
        run && kind == TW_FAST && ctrl_q[TW_COM_B_LO +: 2] == TW_COM_TOGGLE |=> $stable(oc_q[1]))
        else $error("reserved code changed b");
    chk_phase_down_a: assert property (
        kind == TW_PHASE && !up_q && hit[0] && ctrl_q[TW_COM_A_LO +: 2] == TW_COM_CLEAR
        && cmp_act_q[0] != top |=> oc_q[0]) else $error("no set on down match");
    chk_phase_up_b: assert property (
        kind == TW_PHASE && up_q && hit[1] && ctrl_q[TW_COM_B_LO +: 2] == TW_COM_SET
        && cmp_act_q[1] != top |=> oc_q[1]) else $error("no set on up match");
    chk_fast_top_a: assert property (
        s_fast_wrap and ctrl_q[TW_COM_A_LO +: 2] == TW_COM_SET && cmp_act_q[0] == top
        |=> !oc_q[0]) else $error("match at top not ignored");
    chk_phase_top_b: assert property (
        run && kind == TW_PHASE && at_top && ctrl_q[TW_COM_B_LO +: 2] == TW_COM_CLEAR
        && cmp_act_q[1] == top |=> oc_q[1]) else $error("no action at top");
    chk_resv_read: assert property (rvalid && rd_ctrl_q |-> rdata[3:2] == 2'h0)
        else $error("reserved bits read nonzero");
    chk_resv_mode: assert property (run && kind == TW_RESV |=> $stable(count_q))
        else $error("counter moved in reserved mode");
    chk_normal_ovf: assert property (
        run && kind == TW_NORMAL && count_q == TW_MAX |=> st_q[TW_ST_OVF] && count_q == TW_BOTTOM)
        else $error("normal overflow wrong");
    chk_phase_buffer: assert property (kind == TW_PHASE && !(run && at_top)
        |=> $stable(cmp_act_q[1])) else $error("compare loaded off top");
    chk_fast_wrap: assert property (
        s_fast_wrap |=> count_q == TW_BOTTOM && st_q[TW_ST_OVF]) else $error("fast wrap wrong");
    chk_phase_turn: assert property (
        run && kind == TW_PHASE && up_q && at_top && top != TW_BOTTOM
        |=> count_q == $past(count_q) - 8'h01 && !up_q) else $error("phase turn wrong");
    chk_write_answer: assert property (
        s_both_taken |-> ##[TW_WR_LAT_MIN:TW_WR_LAT_MAX] bvalid) else $error("no write answer");
endmodule // tw_waveform_ctrl

// file: tb/tw_pin_load.sv
`timescale 1ns/1ps
module tw_pin_load (
    // clock
    input logic clk,
    // compare pin from the device
    input logic pin_out,
    input logic pin_oe,
    // level the load sees
    output logic pad
);
    logic last_q = 1'b0;
    // no pull on the pad: undriven it shows a changing level
    assign pad = pin_oe ? pin_out : ~last_q;
    always_ff @(posedge clk) begin
        last_q <= pad;
    end
endmodule // tw_pin_load

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import tw_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] wd; logic [7:0] rd; logic [1:0] rs;} tw_row_t;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, pad_a, pad_b;
    logic port_out_a, port_out_b, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
    logic [7:0] awaddr, araddr, rd;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    int n_mismatch = 0;
    int total_checks = 0;
    int hi_a, hi_b, tg_a, tg_b, k;
    tw_row_t rows [8] = '{
        '{TW_OFS_CTRL_A, 8'hff, 8'hf3, TW_RESP_OKAY},
        '{TW_OFS_CTRL_A, 8'h0c, 8'h00, TW_RESP_OKAY},
        '{TW_OFS_CMP_A, 8'h5a, 8'h5a, TW_RESP_OKAY},
        '{TW_OFS_COMP, 8'hf6, 8'h00, TW_RESP_OKAY},
        '{TW_OFS_MASK, 8'hf8, 8'h00, TW_RESP_OKAY},
        '{TW_OFS_PIN_DIR, 8'hfc, 8'h00, TW_RESP_OKAY},
        '{TW_OFS_COUNT, 8'h77, 8'h00, TW_RESP_OKAY},
        '{8'h00, 8'h11, 8'h00, TW_RESP_SLVERR}};

    tw_waveform_ctrl i_dut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .port_out_a(port_out_a), .port_out_b(port_out_b), .pin_a_out(pin_a_out),
        .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .irq(irq));
    tw_pin_load i_load_a (.clk(clk), .pin_out(pin_a_out), .pin_oe(pin_a_oe), .pad(pad_a));
    tw_pin_load i_load_b (.clk(clk), .pin_out(pin_b_out), .pin_oe(pin_b_oe), .pad(pad_b));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        total_checks++;
        if (g < lo || g > hi) begin
            n_mismatch++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        logic pa, pw;
        @(posedge clk);
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw) begin
            @(posedge clk);
            if (pa && awready === 1'b1) begin
                pa = 1'b0;
                awvalid <= 1'b0;
            end
            if (pw && wready === 1'b1) begin
                pw = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic cfg(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, d, r);
    endtask

    // counts high cycles and level changes on both pads
    task automatic meas(input int n, input int settle);
        logic pa, pb;
        repeat (settle) @(posedge clk);
        pa = pad_a;
        pb = pad_b;
        hi_a = 0;
        hi_b = 0;
        tg_a = 0;
        tg_b = 0;
        repeat (n) begin
            @(posedge clk);
            hi_a += int'(pad_a === 1'b1);
            hi_b += int'(pad_b === 1'b1);
            tg_a += int'(pad_a !== pa);
            tg_b += int'(pad_b !== pb);
            pa = pad_a;
            pb = pad_b;
        end
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #400_000;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, wstrb} = '0;
        port_out_a = 1'b1;
        port_out_b = 1'b0;
        do_reset();
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].wd, rs);
            chk("bresp", {6'h0, rows[i].rs}, {6'h0, rs});
            rdr(rows[i].a, rd, rs);
            chk("rdata", rows[i].rd, rd);
            chk("rresp", {6'h0, rows[i].rs}, {6'h0, rs});
        end
        $display("test registers done");
        // mid-run reset, then pin takeover and direction
        cfg(TW_OFS_CTRL_A, 8'hf3);
        do_reset();
        rdr(TW_OFS_CTRL_A, rd, rs);
        chk("ctrl_a_reset", TW_REG_RESET, rd);
        cfg(TW_OFS_PIN_DIR, 8'h01);
        chk("pad_a_port", 8'h01, {7'h0, pad_a});
        cfg(TW_OFS_CTRL_A, 8'h80);
        chk("pad_a_cmp", 8'h00, {7'h0, pad_a});
        cfg(TW_OFS_PIN_DIR, 8'h00);
        chk("oe_a_off", 8'h00, {7'h0, pin_a_oe});
        $display("test pins done");
        cfg(TW_OFS_CMP_A, 8'h04);
        cfg(TW_OFS_PIN_DIR, 8'h03);
        cfg(TW_OFS_CTRL_A, 8'h62);
        cfg(TW_OFS_COMP, 8'h01);
        meas(100, 10);
        chk_rng("ctc_toggles", 19, 21, tg_a);
        chk_rng("ctc_low_b", 0, 0, hi_b);
        $display("test clear on match done");
        cfg(TW_OFS_CMP_B, 8'h80);
        cfg(TW_OFS_CMP_A, 8'h40);
        cfg(TW_OFS_CTRL_A, 8'ha3);
        meas(512, 300);
        chk_rng("fast_hi_a", 128, 132, hi_a);
        chk_rng("fast_hi_b", 256, 260, hi_b);
        cfg(TW_OFS_CTRL_A, 8'hf3);
        meas(512, 260);
        chk_rng("fast_inv_a", 380, 384, hi_a);
        chk_rng("fast_inv_b", 252, 256, hi_b);
        cfg(TW_OFS_CTRL_A, 8'h53);
        meas(300, 260);
        chk_rng("fast_tog_off_a", 300, 300, hi_a);
        chk_rng("fast_resv_b", 0, 0, tg_b);
        cfg(TW_OFS_CMP_A, 8'h09);
        cfg(TW_OFS_COMP, 8'h09);
        meas(100, 300);
        chk_rng("fast_top_tog_a", 9, 11, tg_a);
        cfg(TW_OFS_CTRL_A, 8'h83);
        meas(100, 30);
        chk_rng("fast_top_hi_a", 100, 100, hi_a);
        cfg(TW_OFS_CTRL_A, 8'hc3);
        meas(100, 30);
        chk_rng("fast_top_lo_a", 0, 0, hi_a);
        $display("test fast pwm done");
        cfg(TW_OFS_CMP_B, 8'h09);
        cfg(TW_OFS_CTRL_A, 8'ha1);
        meas(100, 40);
        chk_rng("phase_top_hi_a", 100, 100, hi_a);
        chk_rng("phase_top_hi_b", 100, 100, hi_b);
        cfg(TW_OFS_COMP, 8'h01);
        cfg(TW_OFS_CMP_A, 8'h40);
        cfg(TW_OFS_CMP_B, 8'h80);
        cfg(TW_OFS_CTRL_A, 8'hb1);
        meas(1020, 1100);
        chk_rng("phase_hi_a", 252, 260, hi_a);
        chk_rng("phase_hi_b", 504, 512, hi_b);
        $display("test phase pwm done");
        do_reset();
        cfg(TW_OFS_MASK, 8'h01);
        cfg(TW_OFS_CTRL_A, 8'h40);
        cfg(TW_OFS_COMP, 8'h01);
        k = 0;
        while (irq !== 1'b1 && k < 300) begin
            @(posedge clk);
            k++;
        end
        chk("irq_ovf", 8'h01, {7'h0, irq});
        cfg(TW_OFS_MASK, 8'h00);
        chk("irq_masked", 8'h00, {7'h0, irq});
        cfg(TW_OFS_COMP, 8'h00);
        rdr(TW_OFS_STATUS, rd, rs);
        chk("status", 8'h07, rd);
        rdr(TW_OFS_STATUS, rd, rs);
        chk("status_clr", 8'h00, rd);
        cfg(TW_OFS_MASK, 8'h01);
        chk("irq_clr", 8'h00, {7'h0, irq});
        $display("test interrupt done");
        do_reset();
        cfg(TW_OFS_COMP, 8'h09);
        repeat (20) @(posedge clk);
        rdr(TW_OFS_COUNT, rd, rs);
        chk("resv_mode_count", 8'h00, rd);
        cfg(TW_OFS_CTRL_A, 8'h02);
        repeat (20) @(posedge clk);
        rdr(TW_OFS_COUNT, rd, rs);
        chk("resv_mode6_count", 8'h00, rd);
        $display("test reserved mode done");
        wrap_up();
    end
endmodule // tb_top
